// [branch_increment_pkg.sv]
// shared constants for the branch and increment execute block
package branch_increment_pkg;
   localparam int INSN_W = 12;
   localparam int DATA_W = 8;
   localparam int PC_W = 11;
   localparam int FADDR_W = 5;
   localparam int JUMP_W = 9;
   // opcode fields
   localparam logic [2:0] OPC_JUMP = 3'h5;
   localparam logic [5:0] OPC_INC = 6'h0A;
   localparam logic [5:0] OPC_INC_SKIP = 6'h0F;
   localparam int OPC3_HI = 11;
   localparam int OPC3_LO = 9;
   localparam int OPC6_HI = 11;
   localparam int OPC6_LO = 6;
   localparam int DIR_BIT = 5;
   localparam int FADDR_HI = 4;
   localparam int PAGE_HI = 6;
   localparam int PAGE_LO = 5;
   localparam int ZERO_BIT = 2;
   localparam logic [DATA_W-1:0] ONE = 8'h01;
   localparam logic [DATA_W-1:0] ZERO = 8'h00;
   localparam logic [PC_W-1:0] PC_RESET = 11'h7FF;
   localparam logic [INSN_W-1:0] NOP_WORD = 12'h000;
   // exec state codes
   typedef enum logic [1:0] {
      ST_EXEC  = 2'b01,
      ST_FLUSH = 2'b10
   } exec_state_t;
endpackage : branch_increment_pkg

// [insn_class_decode.sv]
// opcode classifier for the three handled instructions
`timescale 1ns/1ps
`default_nettype none
module insn_class_decode (
   // instruction word
   input wire logic [branch_increment_pkg::INSN_W-1:0] insn_i,
   // classes
   output logic is_jump_o,
   output logic is_inc_o,
   output logic is_inc_skip_o
);
   import branch_increment_pkg::*;

   function automatic logic match6(input logic [INSN_W-1:0] w, input logic [5:0] opc);
      match6 = (w[OPC6_HI:OPC6_LO] == opc);
   endfunction : match6

   assign is_jump_o = (insn_i[OPC3_HI:OPC3_LO] == OPC_JUMP);
   assign is_inc_o = match6(insn_i, OPC_INC);
   assign is_inc_skip_o = match6(insn_i, OPC_INC_SKIP);
endmodule : insn_class_decode
`default_nettype wire

// [branch_increment_execute.sv]
// execute stage for jump, increment and increment-skip-on-zero
`timescale 1ns/1ps
`default_nettype none
module branch_increment_execute (
   // clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // fetched instruction
   input wire logic insn_valid_i,
   input wire logic [branch_increment_pkg::INSN_W-1:0] insn_i,
   // operands
   input wire logic [branch_increment_pkg::DATA_W-1:0] file_rdata_i,
   input wire logic [branch_increment_pkg::DATA_W-1:0] status_i,
   // file register read address
   output logic [branch_increment_pkg::FADDR_W-1:0] file_raddr_o,
   // results
   output logic [branch_increment_pkg::PC_W-1:0] pc_o,
   output logic pc_load_o,
   output logic [branch_increment_pkg::DATA_W-1:0] w_o,
   output logic w_we_o,
   output logic [branch_increment_pkg::FADDR_W-1:0] file_waddr_o,
   output logic [branch_increment_pkg::DATA_W-1:0] file_wdata_o,
   output logic file_we_o,
   output logic [branch_increment_pkg::DATA_W-1:0] status_wdata_o,
   output logic status_we_o,
   // pipeline
   output logic flush_o,
   output logic busy_o
);
   import branch_increment_pkg::*;

   // decoded classes
   logic is_jump;
   logic is_inc;
   logic is_inc_skip;
   logic is_any_inc;
   // word actually executed this cycle
   logic [INSN_W-1:0] word;
   // incremented operand and its zero test
   logic [DATA_W-1:0] sum;
   logic sum_zero;
   // sequencing state
   exec_state_t state_q;
   exec_state_t state_d;
   // program counter group
   logic [PC_W-1:0] pc_q;
   logic [PC_W-1:0] pc_d;
   logic pc_load_q;
   logic pc_load_d;
   // working register group
   logic [DATA_W-1:0] w_q;
   logic [DATA_W-1:0] w_d;
   logic w_we_q;
   logic w_we_d;
   // file register write group
   logic [DATA_W-1:0] fdata_q;
   logic [DATA_W-1:0] fdata_d;
   logic [FADDR_W-1:0] faddr_q;
   logic [FADDR_W-1:0] faddr_d;
   logic f_we_q;
   logic f_we_d;
   // status write group
   logic [DATA_W-1:0] stat_q;
   logic [DATA_W-1:0] stat_d;
   logic s_we_q;
   logic s_we_d;

   function automatic logic is_zero(input logic [DATA_W-1:0] v);
      is_zero = (v == ZERO);
   endfunction : is_zero

   insn_class_decode u_dec (
      .insn_i(word),
      .is_jump_o(is_jump),
      .is_inc_o(is_inc),
      .is_inc_skip_o(is_inc_skip)
   );

   // flush cycle replaces prefetched word by a nop, so no class fires then
   assign word = (state_q == ST_FLUSH || !insn_valid_i) ? NOP_WORD : insn_i;
   assign file_raddr_o = insn_i[FADDR_HI:0];
   assign is_any_inc = is_inc || is_inc_skip;
   assign sum = file_rdata_i + ONE;
   assign sum_zero = is_zero(sum);

   // sequencing: one extra cycle after a jump or a taken skip
   always_comb begin
      state_d = ST_EXEC;
      unique case (state_q)
         ST_EXEC: begin
            if (is_jump) begin
               state_d = ST_FLUSH;
            end else if (is_inc_skip && sum_zero) begin
               state_d = ST_FLUSH;
            end
         end
         ST_FLUSH: begin
            state_d = ST_EXEC;
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_q <= ST_EXEC;
      end else begin
         state_q <= state_d;
      end
   end

   // program counter: only a jump loads it
   always_comb begin
      pc_d = pc_q;
      pc_load_d = 1'b0;
      if (is_jump) begin
         pc_d[JUMP_W-1:0] = word[JUMP_W-1:0];
         pc_d[PC_W-1:JUMP_W] = status_i[PAGE_HI:PAGE_LO];
         pc_load_d = 1'b1;
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pc_q <= PC_RESET;
         pc_load_q <= 1'b0;
      end else begin
         pc_q <= pc_d;
         pc_load_q <= pc_load_d;
      end
   end

   // working register: increments with direction bit clear
   always_comb begin
      w_d = w_q;
      w_we_d = 1'b0;
      if (is_any_inc && !word[DIR_BIT]) begin
         w_d = sum;
         w_we_d = 1'b1;
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         w_q <= ZERO;
         w_we_q <= 1'b0;
      end else begin
         w_q <= w_d;
         w_we_q <= w_we_d;
      end
   end

   // file register: increments with direction bit set
   always_comb begin
      fdata_d = fdata_q;
      faddr_d = faddr_q;
      f_we_d = 1'b0;
      if (is_any_inc && word[DIR_BIT]) begin
         fdata_d = sum;
         faddr_d = word[FADDR_HI:0];
         f_we_d = 1'b1;
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         fdata_q <= ZERO;
         faddr_q <= '0;
         f_we_q <= 1'b0;
      end else begin
         fdata_q <= fdata_d;
         faddr_q <= faddr_d;
         f_we_q <= f_we_d;
      end
   end

   // status: the whole byte is written back, so other flags pass through
   always_comb begin
      stat_d = stat_q;
      s_we_d = 1'b0;
      if (is_inc) begin
         stat_d = status_i;
         stat_d[ZERO_BIT] = sum_zero;
         s_we_d = 1'b1;
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         stat_q <= ZERO;
         s_we_q <= 1'b0;
      end else begin
         stat_q <= stat_d;
         s_we_q <= s_we_d;
      end
   end

   assign pc_o = pc_q;
   assign pc_load_o = pc_load_q;
   assign w_o = w_q;
   assign w_we_o = w_we_q;
   assign file_waddr_o = faddr_q;
   assign file_wdata_o = fdata_q;
   assign file_we_o = f_we_q;
   assign status_wdata_o = stat_q;
   assign status_we_o = s_we_q;
   assign flush_o = (state_q == ST_FLUSH);
   assign busy_o = flush_o;
endmodule : branch_increment_execute
`default_nettype wire

// [branch_increment_assertions.sv]
// port checker for the execute block
`timescale 1ns/1ps
`default_nettype none
module branch_increment_assertions
   import branch_increment_pkg::*;
(
   // watched ports, grouped to keep the checker short
   input wire logic clk_i, resetn_i, insn_valid_i, pc_load_o, w_we_o, file_we_o, status_we_o, flush_o,
   input wire logic [INSN_W-1:0] insn_i,
   input wire logic [DATA_W-1:0] file_rdata_i, status_i, w_o, file_wdata_o, status_wdata_o,
   input wire logic [PC_W-1:0] pc_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   wire tk = insn_valid_i && !flush_o;
   wire [DATA_W-1:0] y = file_rdata_i + ONE;
   sequence s_jmp; tk && insn_i[11:9] == OPC_JUMP; endsequence
   sequence s_inc; tk && insn_i[11:6] == OPC_INC; endsequence
   sequence s_skp; tk && insn_i[11:6] == OPC_INC_SKIP; endsequence
   a_jump_target: assert property (s_jmp |=> pc_load_o
      && pc_o == {$past(status_i[6:5]), $past(insn_i[8:0])}) else $error("jump target wrong");
   a_jump_cycles: assert property (s_jmp |=> flush_o && !status_we_o ##1 !flush_o) else $error("jump timing");
   a_inc_zero: assert property (s_inc |=> status_we_o && status_wdata_o[2] == ($past(y) == ZERO))
      else $error("zero flag wrong");
   a_to_file: assert property ((s_inc or s_skp) ##0 insn_i[5] |=> file_we_o && !w_we_o
      && file_wdata_o == $past(y)) else $error("file write wrong");
   a_to_w: assert property ((s_inc or s_skp) ##0 !insn_i[5] |=> w_we_o && !file_we_o
      && w_o == $past(y)) else $error("w write wrong");
   a_skip_taken: assert property (s_skp |=> flush_o == ($past(y) == ZERO) && !status_we_o)
      else $error("skip wrong");
   a_flush_nop: assert property (flush_o |=> !pc_load_o && !w_we_o && !file_we_o) else $error("flushed word ran");
   a_flush_one: assert property (flush_o |=> !flush_o) else $error("flush too long");
endmodule : branch_increment_assertions
bind branch_increment_execute branch_increment_assertions i_chk (.*);
`default_nettype wire

// [branch_increment_execute_bench.sv]
// random bench for the execute block
`timescale 1ns/1ps
`default_nettype none
module branch_increment_execute_bench;
   import branch_increment_pkg::*;
   logic clk_i = 0, resetn_i = 0, insn_valid_i = 0, v = 0, fl = 0, nv, j, i, k;
   logic [11:0] insn_i = '0, x = '0, nx;
   logic [7:0] file_rdata_i = '0, status_i = '0, r = '0, s = '0, nr, ns, y, w_o, file_wdata_o, status_wdata_o;
   logic [10:0] pc_o;
   logic [4:0] file_raddr_o, file_waddr_o;
   logic pc_load_o, w_we_o, file_we_o, status_we_o, flush_o, busy_o;
   int mismatches = 0, tests_run = 0, cyc = 0;
   branch_increment_execute i_dut (.*);
   initial forever #2 clk_i = ~clk_i;
   task automatic close_out;
      if (mismatches == 0 && tests_run > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : close_out
   task automatic cmp(string n, logic [10:0] e, logic [10:0] g);
      tests_run++;
      if (g !== e) begin
         mismatches++;
         $display("[ERR] %s exp %h got %h", n, e, g);
      end
   endtask : cmp
   // run is about 1500 cycles, well under the 3000-cycle limit that ends a hang
   always @(posedge clk_i) if (++cyc > 3000) begin
      mismatches++;
      close_out();
   end
   initial begin
      void'($urandom(32'h6e8f_ebc9));
      repeat (20) @(posedge clk_i);
      cmp("pc_reset", PC_RESET, pc_o);
      resetn_i <= 1;
      repeat (1500) begin
         @(posedge clk_i);
         nv = $urandom % 8 != 0;
         nx = 12'($urandom);
         case ($urandom % 4)
            0: nx[11:9] = OPC_JUMP;
            1: nx[11:6] = OPC_INC;
            2: nx[11:6] = OPC_INC_SKIP;
            default: ;
         endcase
         // all ones often, to hit the wrap to zero
         nr = ($urandom % 2) ? 8'hFF : 8'($urandom);
         ns = 8'($urandom);
         insn_valid_i <= nv;
         insn_i <= nx;
         file_rdata_i <= nr;
         status_i <= ns;
         #1;
         j = v && !fl && x[11:9] == OPC_JUMP;
         i = v && !fl && x[11:6] == OPC_INC;
         k = v && !fl && x[11:6] == OPC_INC_SKIP;
         y = r + ONE;
         cmp("pulses", {j, (i | k) & !x[5], (i | k) & x[5], i, {2{j | (k & y == ZERO)}}},
            {pc_load_o, w_we_o, file_we_o, status_we_o, flush_o, busy_o});
         cmp("raddr", nx[4:0], file_raddr_o);
         if (j) cmp("pc", {s[6:5], x[8:0]}, pc_o);
         if (i | k) cmp("data", y, x[5] ? file_wdata_o : w_o);
         if ((i | k) & x[5]) cmp("addr", x[4:0], file_waddr_o);
         if (i) cmp("status", {s[7:3], y == ZERO, s[1:0]}, status_wdata_o);
         fl = j | (k & y == ZERO);
         {v, x, r, s} = {nv, nx, nr, ns};
      end
      close_out();
   end
endmodule : branch_increment_execute_bench
`default_nettype wire
